// ===== hdl/tsaux_defines.vh
`ifndef TSAUX_DEFINES_VH
`define TSAUX_DEFINES_VH
// ****************************************
// Register byte offsets
// ****************************************
`define TSAUX_OFF_CTRL     8'h00
`define TSAUX_OFF_PINCFG   8'h04
`define TSAUX_OFF_TT0_LO   8'h08
`define TSAUX_OFF_TT0_HI   8'h0c
`define TSAUX_OFF_TT1_LO   8'h10
`define TSAUX_OFF_TT1_HI   8'h14
`define TSAUX_OFF_HP0      8'h18
`define TSAUX_OFF_HP1      8'h1c
`define TSAUX_OFF_AUX0_LO  8'h20
`define TSAUX_OFF_AUX0_HI  8'h24
`define TSAUX_OFF_AUX1_LO  8'h28
`define TSAUX_OFF_AUX1_HI  8'h2c
`define TSAUX_OFF_CAUSE    8'h30
`define TSAUX_OFF_MASK     8'h34
`define TSAUX_OFF_MAIN     8'h38
// ****************************************
// Control register fields
// ****************************************
`define TSAUX_C_TGT_EN0    0
`define TSAUX_C_TGT_EN1    1
`define TSAUX_C_CLK_EN0    2
`define TSAUX_C_CLK_EN1    3
`define TSAUX_C_START0     4
`define TSAUX_C_START1     5
`define TSAUX_C_PULSE      6
`define TSAUX_C_ACLR_DIS   7
`define TSAUX_C_CAP_EN0    8
`define TSAUX_C_CAP_EN1    9
`define TSAUX_C_SW_SAMP0   10
`define TSAUX_C_SW_SAMP1   11
`define TSAUX_C_FLAG0      12
`define TSAUX_C_FLAG1      13
`define TSAUX_C_GIE        14
// ****************************************
// Pin config fields (per pin: 3 bits at 3*i)
// ****************************************
`define TSAUX_P_AUX0_SEL   12
`define TSAUX_P_AUX0_EN    14
`define TSAUX_P_AUX1_SEL   15
`define TSAUX_P_AUX1_EN    17
// ****************************************
// Cause bits and reset values
// ****************************************
`define TSAUX_I_TT0        0
`define TSAUX_I_TT1        1
`define TSAUX_I_CAP0       2
`define TSAUX_I_CAP1       3
`define TSAUX_RST_WORD     32'h00000000
`define TSAUX_RESP_OKAY    2'b00
`define TSAUX_RESP_SLVERR  2'b10
`endif

// ===== hdl/tsaux_top.v
// Behaviour
// RL1: Targets compared; reaching them drives assigned pins
// RL2: Pin handed over only when enabled
// RL3: Selector 00/01 ties level change to target
// RL4: Selector 10/11 makes clock from target
// RL5: Level mode toggles pin once
// RL6: Without auto-clear-disable, target enable self-clears
// RL7: Pulse: target zero leads, one trails
// RL8: Pulse active with pulse bit, both enables
// RL9: Pin toggles at zero, returns at one
// RL10: Software sets target zero below one
// RL11: Two clock outputs, one target each
// RL12: Each clock has half-period register
// RL13: Clock starts low, now or at target
// RL14: Enabled clock adds half-period, inverts pin
// RL15: Clock match raises cause while enabled
// RL16: Software clears target enable with clock
// RL17: Software sets pin direction and function
// RL18: Software selects pin, enables capture
// RL19: Pin edge latches time, sets flags
// RL20: Capture interrupt needs mask and global
// RL21: High word read clears flag, re-arms
// RL22: Software sample latches time, sets flag
// RL23: Unmasked cause sets main time-sync bit
// RL24: Wide registers act on high half
// RL25: Compare concatenated seconds and nanoseconds unsigned
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "tsaux_defines.vh"
module tsaux_top #(
	parameter NPIN = 4
) (
	input  wire        I_CORE_CLK,
	input  wire        I_RST,
	input  wire [31:0] I_SYS_SEC,
	input  wire [31:0] I_SYS_NS,
	input  wire [NPIN-1:0] I_PIN,
	output reg  [NPIN-1:0] O_PIN,
	output reg  [NPIN-1:0] O_PIN_OE,
	output reg         O_IRQ,
	input  wire [7:0]  I_AWADDR,
	input  wire        I_AWVALID,
	output reg         O_AWREADY,
	input  wire [31:0] I_WDATA,
	input  wire [3:0]  I_WSTRB,
	input  wire        I_WVALID,
	output reg         O_WREADY,
	output reg  [1:0]  O_BRESP,
	output reg         O_BVALID,
	input  wire        I_BREADY,
	input  wire [7:0]  I_ARADDR,
	input  wire        I_ARVALID,
	output reg         O_ARREADY,
	output reg  [31:0] O_RDATA,
	output reg  [1:0]  O_RRESP,
	output reg         O_RVALID,
	input  wire        I_RREADY
);
// ****************************************
// Registers
// ****************************************
reg  [31:0] ctrl_reg;
reg  [17:0] pincfg_reg;
reg  [63:0] tt0_reg;
reg  [63:0] tt1_reg;
reg  [31:0] tt0_lo_stage_reg;
reg  [31:0] tt1_lo_stage_reg;
reg  [31:0] hp0_reg;
reg  [31:0] hp1_reg;
reg  [63:0] aux0_reg;
reg  [63:0] aux1_reg;
reg  [3:0]  cause_reg;
reg  [3:0]  mask_reg;
reg  [NPIN-1:0] pin_s1_reg;
reg  [NPIN-1:0] pin_s2_reg;
reg  [NPIN-1:0] pin_s3_reg;
reg  [NPIN-1:0] lvl_reg;
reg  [1:0]  clk_reg;
reg  [1:0]  clk_run_reg;
reg  [7:0]  awaddr_reg;
reg         aw_have_reg;
reg  [31:0] wdata_reg;
reg  [3:0]  wstrb_reg;
reg         w_have_reg;
wire [63:0] now = {I_SYS_SEC, I_SYS_NS};
wire        hit0 = now >= tt0_reg; // RL25
wire        hit1 = now >= tt1_reg; // RL25
wire        en0 = ctrl_reg[`TSAUX_C_TGT_EN0];
wire        en1 = ctrl_reg[`TSAUX_C_TGT_EN1];
wire        pulse = ctrl_reg[`TSAUX_C_PULSE] & en0 & en1; // RL8
wire        fire0 = en0 & hit0 & ~clk_run_reg[0]; // RL1
wire        fire1 = en1 & hit1 & ~clk_run_reg[1]; // RL1
wire [1:0]  cen = {ctrl_reg[`TSAUX_C_CLK_EN1], ctrl_reg[`TSAUX_C_CLK_EN0]};
wire [1:0]  cstart = {ctrl_reg[`TSAUX_C_START1], ctrl_reg[`TSAUX_C_START0]};
wire [1:0]  chit = {hit1, hit0};
wire [1:0]  ctick = clk_run_reg & chit; // RL14
// Start cycle advances the target too, so the first edge is a half period on
wire [1:0]  cgo = cen & ~clk_run_reg & (~cstart | chit); // RL13
// Capture edges; third stage only feeds edge detect
wire [NPIN-1:0] edg = pin_s2_reg ^ pin_s3_reg;
wire        e0 = pincfg_reg[`TSAUX_P_AUX0_EN] &
	edg[pincfg_reg[`TSAUX_P_AUX0_SEL+1:`TSAUX_P_AUX0_SEL]];
wire        e1 = pincfg_reg[`TSAUX_P_AUX1_EN] &
	edg[pincfg_reg[`TSAUX_P_AUX1_SEL+1:`TSAUX_P_AUX1_SEL]];
// ****************************************
// Bus decode
// ****************************************
wire        wr_go = aw_have_reg & w_have_reg & ~O_BVALID;
wire        rd_go = I_ARVALID & O_ARREADY;
wire [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
	{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
wire        wr_ctrl = wr_go & (awaddr_reg == `TSAUX_OFF_CTRL);
wire [31:0] wr_val = wdata_reg & wmask;
wire        sw0 = wr_ctrl & wr_val[`TSAUX_C_SW_SAMP0];
wire        sw1 = wr_ctrl & wr_val[`TSAUX_C_SW_SAMP1];
wire        rd_aux0_hi = rd_go & (I_ARADDR == `TSAUX_OFF_AUX0_HI);
wire        rd_aux1_hi = rd_go & (I_ARADDR == `TSAUX_OFF_AUX1_HI);
wire        flag0 = ctrl_reg[`TSAUX_C_FLAG0];
wire        flag1 = ctrl_reg[`TSAUX_C_FLAG1];
wire        cap0 = ~flag0 & (sw0 | (e0 & ctrl_reg[`TSAUX_C_CAP_EN0]));
wire        cap1 = ~flag1 & (sw1 | (e1 & ctrl_reg[`TSAUX_C_CAP_EN1]));
wire        main_bit = |(cause_reg & mask_reg); // RL23
reg  [31:0] rd_mux;
reg         rd_ok;
always @* begin
	rd_ok = 1'b1;
	case (I_ARADDR)
	`TSAUX_OFF_CTRL:    rd_mux = ctrl_reg;
	`TSAUX_OFF_PINCFG:  rd_mux = {14'h0000, pincfg_reg};
	`TSAUX_OFF_TT0_LO:  rd_mux = tt0_reg[31:0];
	`TSAUX_OFF_TT0_HI:  rd_mux = tt0_reg[63:32];
	`TSAUX_OFF_TT1_LO:  rd_mux = tt1_reg[31:0];
	`TSAUX_OFF_TT1_HI:  rd_mux = tt1_reg[63:32];
	`TSAUX_OFF_HP0:     rd_mux = hp0_reg;
	`TSAUX_OFF_HP1:     rd_mux = hp1_reg;
	`TSAUX_OFF_AUX0_LO: rd_mux = aux0_reg[31:0];
	`TSAUX_OFF_AUX0_HI: rd_mux = aux0_reg[63:32];
	`TSAUX_OFF_AUX1_LO: rd_mux = aux1_reg[31:0];
	`TSAUX_OFF_AUX1_HI: rd_mux = aux1_reg[63:32];
	`TSAUX_OFF_CAUSE:   rd_mux = {28'h0000000, cause_reg};
	`TSAUX_OFF_MASK:    rd_mux = {28'h0000000, mask_reg};
	`TSAUX_OFF_MAIN:    rd_mux = {31'h00000000, main_bit};
	default: begin
		rd_mux = `TSAUX_RST_WORD;
		rd_ok = 1'b0;
	end
	endcase
end
// ****************************************
// AXI4-Lite handshakes
// ****************************************
always @(posedge I_CORE_CLK or posedge I_RST) begin
	if (I_RST) begin
		O_AWREADY <= 1'b0;
		O_WREADY <= 1'b0;
		O_BVALID <= 1'b0;
		O_BRESP <= `TSAUX_RESP_OKAY;
		O_ARREADY <= 1'b0;
		O_RVALID <= 1'b0;
		O_RDATA <= `TSAUX_RST_WORD;
		O_RRESP <= `TSAUX_RESP_OKAY;
		aw_have_reg <= 1'b0;
		w_have_reg <= 1'b0;
		awaddr_reg <= 8'h00;
		wdata_reg <= `TSAUX_RST_WORD;
		wstrb_reg <= 4'h0;
	end else begin
		O_AWREADY <= ~aw_have_reg & ~(I_AWVALID & O_AWREADY);
		O_WREADY <= ~w_have_reg & ~(I_WVALID & O_WREADY);
		if (I_AWVALID & O_AWREADY) begin
			aw_have_reg <= 1'b1;
			awaddr_reg <= I_AWADDR;
		end
		if (I_WVALID & O_WREADY) begin
			w_have_reg <= 1'b1;
			wdata_reg <= I_WDATA;
			wstrb_reg <= I_WSTRB;
		end
		if (wr_go) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			O_BVALID <= 1'b1;
			O_BRESP <= (awaddr_reg <= `TSAUX_OFF_MASK &&
				awaddr_reg[1:0] == 2'b00 &&
				awaddr_reg != `TSAUX_OFF_AUX0_LO &&
				awaddr_reg != `TSAUX_OFF_AUX0_HI &&
				awaddr_reg != `TSAUX_OFF_AUX1_LO &&
				awaddr_reg != `TSAUX_OFF_AUX1_HI) ?
				`TSAUX_RESP_OKAY : `TSAUX_RESP_SLVERR;
		end else if (O_BVALID & I_BREADY) begin
			O_BVALID <= 1'b0;
		end
		O_ARREADY <= ~O_RVALID & ~rd_go;
		if (rd_go) begin
			O_RVALID <= 1'b1;
			O_RDATA <= rd_mux;
			O_RRESP <= rd_ok ? `TSAUX_RESP_OKAY : `TSAUX_RESP_SLVERR;
		end else if (O_RVALID & I_RREADY) begin
			O_RVALID <= 1'b0;
		end
	end
end
// ****************************************
// Config, targets, captures, causes
// ****************************************
always @(posedge I_CORE_CLK or posedge I_RST) begin
	if (I_RST) begin
		ctrl_reg <= `TSAUX_RST_WORD;
		pincfg_reg <= 18'h00000;
		tt0_reg <= 64'h0000000000000000;
		tt1_reg <= 64'h0000000000000000;
		tt0_lo_stage_reg <= `TSAUX_RST_WORD;
		tt1_lo_stage_reg <= `TSAUX_RST_WORD;
		hp0_reg <= `TSAUX_RST_WORD;
		hp1_reg <= `TSAUX_RST_WORD;
		aux0_reg <= 64'h0000000000000000;
		aux1_reg <= 64'h0000000000000000;
		cause_reg <= 4'h0;
		mask_reg <= 4'h0;
		O_IRQ <= 1'b0;
	end else begin
		if (wr_go) begin
			case (awaddr_reg)
			`TSAUX_OFF_CTRL: begin
				ctrl_reg[11:0] <= (ctrl_reg[11:0] & ~wmask[11:0]) |
					(wr_val[11:0] & 12'h3ff);
				ctrl_reg[`TSAUX_C_GIE] <= wmask[`TSAUX_C_GIE] ?
					wr_val[`TSAUX_C_GIE] : ctrl_reg[`TSAUX_C_GIE];
			end
			`TSAUX_OFF_PINCFG:
				pincfg_reg <= (pincfg_reg & ~wmask[17:0]) | wr_val[17:0];
			`TSAUX_OFF_TT0_LO: tt0_lo_stage_reg <= wr_val;
			`TSAUX_OFF_TT0_HI:
				tt0_reg <= {wr_val, tt0_lo_stage_reg}; // RL24
			`TSAUX_OFF_TT1_LO: tt1_lo_stage_reg <= wr_val;
			`TSAUX_OFF_TT1_HI:
				tt1_reg <= {wr_val, tt1_lo_stage_reg}; // RL24
			`TSAUX_OFF_HP0: hp0_reg <= wr_val; // RL12
			`TSAUX_OFF_HP1: hp1_reg <= wr_val; // RL12
			`TSAUX_OFF_MASK: mask_reg <= wr_val[3:0];
			default: begin
			end
			endcase
		end
		// Clock targets advance by half period after each edge
		if (ctick[0] | cgo[0])
			tt0_reg <= tt0_reg + {32'h00000000, hp0_reg}; // RL14
		if (ctick[1] | cgo[1])
			tt1_reg <= tt1_reg + {32'h00000000, hp1_reg}; // RL14
		// One-shot unless auto-clear is disabled: hardware clears enable after firing
		if (~ctrl_reg[`TSAUX_C_ACLR_DIS]) begin
			if (fire0 | (ctick[0] & en0))
				ctrl_reg[`TSAUX_C_TGT_EN0] <= 1'b0; // RL6
			if (fire1 | (ctick[1] & en1))
				ctrl_reg[`TSAUX_C_TGT_EN1] <= 1'b0; // RL6
		end
		// Capture slots; high-word read re-arms, capture wins
		if (cap0) begin
			aux0_reg <= now; // RL19 RL22
			ctrl_reg[`TSAUX_C_FLAG0] <= 1'b1; // RL19
		end else if (rd_aux0_hi) begin
			ctrl_reg[`TSAUX_C_FLAG0] <= 1'b0; // RL21
		end
		if (cap1) begin
			aux1_reg <= now; // RL19 RL22
			ctrl_reg[`TSAUX_C_FLAG1] <= 1'b1; // RL19
		end else if (rd_aux1_hi) begin
			ctrl_reg[`TSAUX_C_FLAG1] <= 1'b0; // RL21
		end
		// Causes: writing one clears, a new event wins
		cause_reg <= (cause_reg & ~((wr_go &&
			awaddr_reg == `TSAUX_OFF_CAUSE) ? wr_val[3:0] : 4'h0)) |
			{cap1, cap0,
			fire1 | (ctick[1] & en1), fire0 | (ctick[0] & en0)}; // RL15
		O_IRQ <= main_bit & ctrl_reg[`TSAUX_C_GIE]; // RL20 RL23
	end
end
// ****************************************
// Pin logic
// ****************************************
always @(posedge I_CORE_CLK or posedge I_RST) begin
	if (I_RST) begin
		pin_s1_reg <= {NPIN{1'b0}};
		pin_s2_reg <= {NPIN{1'b0}};
		pin_s3_reg <= {NPIN{1'b0}};
		clk_reg <= 2'b00;
		clk_run_reg <= 2'b00;
	end else begin
		pin_s1_reg <= I_PIN;
		pin_s2_reg <= pin_s1_reg;
		pin_s3_reg <= pin_s2_reg;
		// Clock starts low; a delayed start waits for the target
		begin : clkgen
			integer k;
			for (k = 0; k < 2; k = k + 1) begin
				if (~cen[k]) begin
					clk_run_reg[k] <= 1'b0;
					clk_reg[k] <= 1'b0;
				end else if (~clk_run_reg[k]) begin
					clk_reg[k] <= 1'b0; // RL13
					if (~cstart[k] | chit[k])
						clk_run_reg[k] <= 1'b1; // RL13
				end else if (chit[k]) begin
					clk_reg[k] <= ~clk_reg[k]; // RL14
				end
			end
		end
	end
end
genvar g;
generate
	for (g = 0; g < NPIN; g = g + 1) begin : pins
		wire [1:0] sel = pincfg_reg[3*g+1:3*g];
		wire       on = pincfg_reg[3*g+2];
		always @(posedge I_CORE_CLK or posedge I_RST) begin
			if (I_RST) begin
				lvl_reg[g] <= 1'b0;
				O_PIN[g] <= 1'b0;
				O_PIN_OE[g] <= 1'b0;
			end else begin
				O_PIN_OE[g] <= on; // RL2
				// Trailing edge still counts once target zero self-clears
				if (on && ctrl_reg[`TSAUX_C_PULSE] && sel == 2'b00) begin
					if ((fire0 & pulse) | fire1)
						lvl_reg[g] <= ~lvl_reg[g]; // RL7 RL9
				end else if (on && sel == 2'b00 && fire0) begin
					lvl_reg[g] <= ~lvl_reg[g]; // RL3 RL5
				end else if (on && sel == 2'b01 && fire1) begin
					lvl_reg[g] <= ~lvl_reg[g]; // RL3 RL5
				end
				O_PIN[g] <= ~on ? 1'b0 : sel[1] ?
					clk_reg[sel[0]] : lvl_reg[g]; // RL2 RL4 RL11
			end
		end
	end
endgenerate
endmodule // tsaux_top

// ===== verif/tsaux_pin_model.sv
`timescale 1ns/1ps
// ****************************************
// External pin hardware
// ****************************************
module tsaux_pin_model (
	input  logic       i_clk,
	input  logic [3:0] i_pin,
	input  logic [3:0] i_oe,
	output logic [3:0] o_wire
);
	logic [3:0] ext_reg;
	initial ext_reg = 4'h0;
	// Device owns the wire only while it drives it
	assign o_wire = (i_oe & i_pin) | (~i_oe & ext_reg);
	// A delay lets the far side answer late as well as at once
	task automatic toggle(input int idx, input int dly);
		repeat (dly) @(posedge i_clk);
		ext_reg[idx] <= ~ext_reg[idx];
	endtask
endmodule // tsaux_pin_model

// ===== verif/tsaux_props.sv
`timescale 1ns/1ps
`include "tsaux_defines.vh"
module tsaux_props #(
	parameter NPIN = 4
) (
	input logic            I_CORE_CLK,
	input logic            I_RST,
	input logic [NPIN-1:0] O_PIN_OE,
	input logic            O_IRQ,
	input logic            I_AWVALID,
	input logic            O_AWREADY,
	input logic            I_WVALID,
	input logic            O_WREADY,
	input logic [1:0]      O_BRESP,
	input logic            O_BVALID,
	input logic            I_BREADY,
	input logic [7:0]      I_ARADDR,
	input logic            I_ARVALID,
	input logic            O_ARREADY,
	input logic [31:0]     O_RDATA,
	input logic [1:0]      O_RRESP,
	input logic            O_RVALID,
	input logic            I_RREADY
);
	logic [7:0] ar_reg;
	logic       ev;
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);
	assign ev = (I_AWVALID && O_AWREADY) || (I_WVALID && O_WREADY);
	always @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST)
			ar_reg <= 8'h00;
		else if (I_ARVALID && O_ARREADY)
			ar_reg <= I_ARADDR;
	end
	chk_b_hold: assert property (
		O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
		else $error("write response dropped early");
	chk_r_hold: assert property (
		O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
		else $error("read data dropped early");
	chk_ar_blocked: assert property (
		O_RVALID |-> !(I_ARVALID && O_ARREADY))
		else $error("read taken while answer pending");
	chk_read_answer: assert property (
		I_ARVALID && O_ARREADY |=> O_RVALID)
		else $error("read answer late");
	chk_rd_unmapped: assert property (
		O_RVALID && (ar_reg > 8'h38 || ar_reg[1:0] != 2'b00)
		|-> O_RRESP == `TSAUX_RESP_SLVERR && O_RDATA == 32'h00000000)
		else $error("unmapped read not refused");
	chk_rd_mapped: assert property (
		O_RVALID && ar_reg <= 8'h38 && ar_reg[1:0] == 2'b00
		|-> O_RRESP == `TSAUX_RESP_OKAY)
		else $error("mapped read refused");
	chk_irq_fall: assert property (
		$fell(O_IRQ) |-> $past(ev, 1) || $past(ev, 2) || $past(ev, 3))
		else $error("interrupt fell without a write");
	chk_oe_write: assert property (
		$changed(O_PIN_OE) |-> $past(ev, 1) || $past(ev, 2) || $past(ev, 3))
		else $error("pin enable moved without a write");
	cover property ($rose(O_IRQ));
	cover property ($rose(O_PIN_OE[NPIN-1]));
	cover property (O_RVALID && O_RRESP == `TSAUX_RESP_SLVERR);
endmodule // tsaux_props
bind tsaux_top tsaux_props #(.NPIN(NPIN)) tsaux_props_inst (.I_CORE_CLK,
	.I_RST, .O_PIN_OE, .O_IRQ, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY,
	.O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY,
	.O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY);

// ===== verif/tb.sv
`timescale 1ns/1ps
`include "tsaux_defines.vh"
module tb;
	logic        I_CORE_CLK, I_RST, O_IRQ, I_AWVALID, O_AWREADY, I_WVALID;
	logic        O_WREADY, O_BVALID, I_BREADY, I_ARVALID, O_ARREADY;
	logic        O_RVALID, I_RREADY;
	logic [31:0] I_SYS_SEC, I_SYS_NS, I_WDATA, O_RDATA, d, s;
	logic [3:0]  I_PIN, O_PIN, O_PIN_OE, I_WSTRB;
	logic [7:0]  I_AWADDR, I_ARADDR;
	logic [1:0]  O_BRESP, O_RRESP, r;
	logic [63:0] now, t0;
	int          n_mismatch, num_checks, cyc, k;
	assign now = {I_SYS_SEC, I_SYS_NS};
	tsaux_top #(.NPIN(4)) tsaux_top_inst (.I_CORE_CLK, .I_RST, .I_SYS_SEC,
		.I_SYS_NS, .I_PIN, .O_PIN, .O_PIN_OE, .O_IRQ, .I_AWADDR, .I_AWVALID,
		.O_AWREADY, .I_WDATA, .I_WSTRB, .I_WVALID, .O_WREADY, .O_BRESP,
		.O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA,
		.O_RRESP, .O_RVALID, .I_RREADY);
	tsaux_pin_model tsaux_pin_model_inst (.i_clk(I_CORE_CLK), .i_pin(O_PIN),
		.i_oe(O_PIN_OE), .o_wire(I_PIN));
	initial begin
		I_CORE_CLK = 1'b0;
		forever #5 I_CORE_CLK = ~I_CORE_CLK;
	end
	// Time starts just short of a seconds wrap to expose split compares
	always @(posedge I_CORE_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test;
		end
		if (I_SYS_NS >= 32'h3b9ac9f6) begin
			I_SYS_NS <= 32'h00000000;
			I_SYS_SEC <= I_SYS_SEC + 32'h1;
		end else
			I_SYS_NS <= I_SYS_NS + 32'ha;
	end
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t value %h expected %h", $time, g, e);
		end
	endtask
	task automatic chkr(input logic [63:0] g, lo, hi);
		num_checks++;
		if ((g >= lo && g <= hi) !== 1'b1) begin
			n_mismatch++;
			$display("ERROR %0t time %h outside %h..%h", $time, g, lo, hi);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		I_AWADDR <= a;
		I_WDATA <= v;
		I_AWVALID <= 1'b1;
		I_WVALID <= 1'b1;
		while (!(aw && w)) begin
			@(posedge I_CORE_CLK);
			if (O_AWREADY && !aw) begin
				aw = 1'b1;
				I_AWVALID <= 1'b0;
			end
			if (O_WREADY && !w) begin
				w = 1'b1;
				I_WVALID <= 1'b0;
			end
		end
		do @(posedge I_CORE_CLK); while (!O_BVALID);
		I_BREADY <= 1'b1;
		@(posedge I_CORE_CLK);
		r = O_BRESP;
		I_BREADY <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		I_ARADDR <= a;
		I_ARVALID <= 1'b1;
		do @(posedge I_CORE_CLK); while (!O_ARREADY);
		I_ARVALID <= 1'b0;
		do @(posedge I_CORE_CLK); while (!O_RVALID);
		I_RREADY <= 1'b1;
		@(posedge I_CORE_CLK);
		v = O_RDATA;
		r = O_RRESP;
		I_RREADY <= 1'b0;
	endtask
	task automatic wtt(input logic [7:0] a, input logic [63:0] t);
		wr(a, t[31:0]);
		wr(a + 8'h4, t[63:32]);
	endtask
	task automatic wsig(input int i, input logic v, output int n);
		n = 0;
		while (((i < 4) ? O_PIN[i] : O_IRQ) !== v && n < 3000) begin
			@(posedge I_CORE_CLK);
			n++;
		end
		if (n >= 3000) chk32(32'h0, 32'h1);
	endtask
	task automatic end_of_test;
		$display("Checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		{n_mismatch, num_checks, cyc} = '0;
		{I_AWADDR, I_ARADDR, I_WDATA, I_AWVALID, I_WVALID} = '0;
		{I_BREADY, I_ARVALID, I_RREADY} = '0;
		{I_RST, I_WSTRB, I_SYS_SEC, I_SYS_NS} = {1'b1, 4'hf, 64'h53b9ac618};
		repeat (10) @(posedge I_CORE_CLK);
		I_RST <= 1'b0;
		repeat (2) @(posedge I_CORE_CLK);
		rd(`TSAUX_OFF_PINCFG, d);
		chk32(d, `TSAUX_RST_WORD);
		rd(8'h40, d);
		chk32({d[29:0], r}, {30'h0, `TSAUX_RESP_SLVERR});
		wr(`TSAUX_OFF_AUX0_LO, 32'h1);
		chk32({30'h0, r}, {30'h0, `TSAUX_RESP_SLVERR});
		wtt(`TSAUX_OFF_TT0_LO, 64'h60000012c);
		wtt(`TSAUX_OFF_TT1_LO, 64'h600000258);
		wr(`TSAUX_OFF_PINCFG, 32'h0000002c);
		wr(`TSAUX_OFF_CTRL, 32'h00000003);
		chk32({28'h0, O_PIN_OE}, 32'h3);
		wsig(0, 1'b1, k);
		chkr(now, 64'h60000012c, 64'h60000015e);
		wsig(1, 1'b1, k);
		chkr(now, 64'h600000258, 64'h60000028a);
		chk32({31'h0, O_PIN[0]}, 32'h1);
		rd(`TSAUX_OFF_CTRL, d);
		chk32(d & 32'h3, 32'h0);
		wr(`TSAUX_OFF_PINCFG, 32'h00000100);
		wtt(`TSAUX_OFF_TT0_LO, 64'h6000007d0);
		wtt(`TSAUX_OFF_TT1_LO, 64'h600000a28);
		wr(`TSAUX_OFF_CTRL, 32'h00000043);
		wsig(2, 1'b1, k);
		chkr(now, 64'h6000007d0, 64'h600000802);
		wsig(2, 1'b0, k);
		chkr(now, 64'h600000a28, 64'h600000a5a);
		wr(`TSAUX_OFF_CAUSE, 32'hf);
		wr(`TSAUX_OFF_PINCFG, 32'h00000c00);
		wr(`TSAUX_OFF_HP0, 32'h000001f4);
		wtt(`TSAUX_OFF_TT0_LO, 64'h600001388);
		wr(`TSAUX_OFF_CTRL, 32'h00000095);
		chk32({31'h0, O_PIN[3]}, 32'h0);
		wsig(3, 1'b1, k);
		chkr(now, 64'h60000157c, 64'h6000015ae);
		wsig(3, 1'b0, k);
		chk32(k, 32'd50);
		wsig(3, 1'b1, k);
		chk32(k, 32'd50);
		wr(`TSAUX_OFF_CAUSE, 32'h1);
		wsig(3, 1'b0, k);
		rd(`TSAUX_OFF_CAUSE, d);
		chk32(d & 32'h1, 32'h1);
		wr(`TSAUX_OFF_CTRL, 32'h0);
		wr(`TSAUX_OFF_CAUSE, 32'hf);
		wr(`TSAUX_OFF_PINCFG, 32'h00004000);
		wr(`TSAUX_OFF_MASK, 32'h4);
		wr(`TSAUX_OFF_CTRL, 32'h00004100);
		t0 = now;
		tsaux_pin_model_inst.toggle(0, 0);
		wsig(4, 1'b1, k);
		tsaux_pin_model_inst.toggle(0, 3);
		repeat (8) @(posedge I_CORE_CLK);
		rd(`TSAUX_OFF_AUX0_LO, s);
		rd(`TSAUX_OFF_AUX0_HI, d);
		chkr({d, s}, t0, t0 + 64'h64);
		rd(`TSAUX_OFF_CTRL, d);
		chk32(d & 32'h1000, 32'h0);
		rd(`TSAUX_OFF_CAUSE, d);
		chk32(d & 32'h4, 32'h4);
		wr(`TSAUX_OFF_CAUSE, 32'h4);
		wsig(4, 1'b0, k);
		t0 = now;
		tsaux_pin_model_inst.toggle(0, 0);
		wsig(4, 1'b1, k);
		rd(`TSAUX_OFF_AUX0_LO, s);
		rd(`TSAUX_OFF_AUX0_HI, d);
		chkr({d, s}, t0, t0 + 64'h64);
		wr(`TSAUX_OFF_CAUSE, 32'hf);
		wr(`TSAUX_OFF_MASK, 32'h0);
		t0 = now;
		wr(`TSAUX_OFF_CTRL, 32'h00004a00);
		rd(`TSAUX_OFF_CTRL, d);
		chk32(d & 32'h2000, 32'h2000);
		chk32({31'h0, O_IRQ}, 32'h0);
		rd(`TSAUX_OFF_AUX1_LO, s);
		rd(`TSAUX_OFF_AUX1_HI, d);
		chkr({d, s}, t0, t0 + 64'hc8);
		end_of_test;
	end
endmodule // tb
